// *** rtl/sfp_pkg.sv ***
// Purpose: Shared types and constants for the serial flash pin interface
// Assumes: One 100 MHz system clock samples every pin
// Notes:   Pin groups and core-side groups travel as packed structs
package sfp_pkg;

   // ==========================================================
   // Widths and counts
   localparam int unsigned BYTE_W    = 8;
   localparam int unsigned LINES_W   = 4;
   localparam int unsigned CNT_W     = 4;
   localparam int unsigned PIN_W     = 6;
   localparam logic [3:0]  CNT_ZERO  = 4'h0;
   localparam logic [3:0]  CNT_BYTE  = 4'h8;
   localparam logic [3:0]  BITS_ONE  = 4'h1;
   localparam logic [3:0]  BITS_TWO  = 4'h2;
   localparam logic [3:0]  BITS_FOUR = 4'h4;

   // ==========================================================
   // Synchroniser bit positions and reset levels
   localparam int unsigned PIN_LINE0 = 0;
   localparam int unsigned PIN_LINE1 = 1;
   localparam int unsigned PIN_LINE2 = 2;
   localparam int unsigned PIN_LINE3 = 3;
   localparam int unsigned PIN_SCLK  = 4;
   localparam int unsigned PIN_CS_N  = 5;
   // Chip select idles deselected, write-protect and pause idle high
   localparam logic [5:0]  PIN_RST   = 6'h2_C;
   localparam logic [7:0]  BYTE_ZERO = 8'h0_0;
   localparam logic [3:0]  LINES_OFF = 4'h0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SFP_SINGLE,
      SFP_DUAL,
      SFP_QUAD
   } sfp_lanes_t;

   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic [3:0] line_i;
   } sfp_pins_t;

   typedef struct packed {
      logic [3:0] line_o;
      logic [3:0] line_oe;
   } sfp_drive_t;

   typedef struct packed {
      logic       rd_phase;
      sfp_lanes_t lanes;
   } sfp_ctl_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } sfp_rx_t;

endpackage

// *** rtl/sfp_pin_sync.sv ***
// Purpose: Three-stage pin synchroniser with filtered level and edge pulses
// Assumes: Inputs are asynchronous to clk
// Notes:   A change counts only once the second and third stages agree
`timescale 1ns/1ns
module sfp_pin_sync #(
   parameter int unsigned W       = 6,
   parameter logic [5:0]  RST_VAL = 6'h0_0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] lvl,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] prev_q;
   logic [W-1:0] lvl_d;

   // ==========================================================
   // Filter
   always_comb begin
      for (int i = 0; i < W; i++) begin
         lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q   <= RST_VAL[W-1:0];
         s2_q   <= RST_VAL[W-1:0];
         s3_q   <= RST_VAL[W-1:0];
         lvl_q  <= RST_VAL[W-1:0];
         prev_q <= RST_VAL[W-1:0];
      end else begin
         s1_q   <= pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         lvl_q  <= lvl_d;
         prev_q <= lvl_q;
      end
   end

   assign lvl  = lvl_q;
   assign rise = lvl_q & ~prev_q;
   assign fall = ~lvl_q & prev_q;

endmodule

// *** rtl/sfp_pin_if.sv ***
// Purpose: Pin-level serial interface of a serial flash device
// Assumes: Host clock and select arrive as pins, sampled by clk
// Notes:   Core decodes instructions and picks lanes and read phase
`timescale 1ns/1ns
module sfp_pin_if (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire sfp_pkg::sfp_pins_t  pins,
   output sfp_pkg::sfp_drive_t      drive,
   input  wire logic                quad_enable_bit,
   input  wire logic                sr_protect,
   input  wire sfp_pkg::sfp_ctl_t   ctl,
   input  wire logic [7:0]          tx_data,
   output logic                     tx_take,
   output sfp_pkg::sfp_rx_t         rx,
   output logic                     selected,
   output logic                     frame_start,
   output logic                     paused,
   output logic                     quad_refused,
   output logic                     wr_status_block
);

   // ==========================================================
   // Pin sampling
   // The filter lags the pins by about four cycles, so each host clock half must be longer
   logic [5:0] pin_lvl;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;

   sfp_pin_sync #(
      .W       (sfp_pkg::PIN_W),
      .RST_VAL (sfp_pkg::PIN_RST)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   ({pins.cs_n, pins.sclk, pins.line_i}),
      .lvl   (pin_lvl),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   logic cs_n_lvl;
   logic cs_fall;
   logic sclk_lvl;
   logic sclk_rise;
   logic sclk_fall;
   logic hold_lvl;
   logic wp_lvl;
   logic [3:0] line_lvl;

   assign cs_n_lvl  = pin_lvl[sfp_pkg::PIN_CS_N];
   assign cs_fall   = pin_fall[sfp_pkg::PIN_CS_N];
   assign sclk_lvl  = pin_lvl[sfp_pkg::PIN_SCLK];
   assign sclk_rise = pin_rise[sfp_pkg::PIN_SCLK];
   assign sclk_fall = pin_fall[sfp_pkg::PIN_SCLK];
   assign hold_lvl  = pin_lvl[sfp_pkg::PIN_LINE3];
   assign wp_lvl    = pin_lvl[sfp_pkg::PIN_LINE2];
   assign line_lvl  = pin_lvl[sfp_pkg::PIN_LINE3:sfp_pkg::PIN_LINE0];

   // ==========================================================
   // Helpers
   // Bits moved per clock edge for each lane width
   function automatic logic [3:0] lane_bits(input sfp_pkg::sfp_lanes_t l);
      unique case (l)
         sfp_pkg::SFP_SINGLE: lane_bits = sfp_pkg::BITS_ONE;
         sfp_pkg::SFP_DUAL:   lane_bits = sfp_pkg::BITS_TWO;
         sfp_pkg::SFP_QUAD:   lane_bits = sfp_pkg::BITS_FOUR;
         default:             lane_bits = sfp_pkg::BITS_ONE;
      endcase
   endfunction

   // ==========================================================
   // State
   logic       armed_q,  armed_d;
   logic       pause_q,  pause_d;
   logic [7:0] shin_q,   shin_d;
   logic [3:0] incnt_q,  incnt_d;
   logic [7:0] rxb_q,    rxb_d;
   logic       rxv_q,    rxv_d;
   logic [7:0] tx_q,     tx_d;
   logic [3:0] outcnt_q, outcnt_d;
   logic [3:0] do_q,     do_d;
   logic [3:0] oe_q,     oe_d;
   logic       take_q,   take_d;

   sfp_pkg::sfp_lanes_t lanes;
   logic       active;
   logic       sel;
   logic [3:0] nbits;
   logic       quad_ok;

   // Quad falls back to single when the enable bit is clear
   assign quad_ok = quad_enable_bit;
   assign lanes   = (ctl.lanes == sfp_pkg::SFP_QUAD && !quad_ok) ?
                    sfp_pkg::SFP_SINGLE : ctl.lanes;
   assign nbits   = lane_bits(lanes);
   // Deselected unless armed and select is low
   assign sel     = armed_q && !cs_n_lvl;
   // A pause only withholds the edges, so shifters and counters resume where they stood
   assign active  = sel && !pause_q;

   always_comb begin
      armed_d  = armed_q;
      pause_d  = pause_q;
      shin_d   = shin_q;
      incnt_d  = incnt_q;
      rxb_d    = rxb_q;
      rxv_d    = 1'b0;
      tx_d     = tx_q;
      outcnt_d = outcnt_q;
      do_d     = do_q;
      oe_d     = oe_q;
      take_d   = 1'b0;

      // First select fall after reset arms the port
      if (cs_fall) begin
         armed_d = 1'b1;
      end

      // Pause follows the pin only while the clock is low
      if (!sel || quad_enable_bit) begin
         pause_d = 1'b0;
      end else if (!sclk_lvl) begin
         pause_d = !hold_lvl;
      end

      // Every new frame restarts framing, whichever idle level the clock had
      if (cs_fall || cs_n_lvl) begin
         incnt_d  = sfp_pkg::CNT_ZERO;
         outcnt_d = sfp_pkg::CNT_ZERO;
         oe_d     = sfp_pkg::LINES_OFF;
      end else if (active) begin
         if (sclk_rise && !ctl.rd_phase) begin
            // Shift in on rising edges
            unique case (lanes)
               sfp_pkg::SFP_SINGLE: shin_d = {shin_q[6:0], line_lvl[0]};
               sfp_pkg::SFP_DUAL:   shin_d = {shin_q[5:0], line_lvl[1:0]};
               sfp_pkg::SFP_QUAD:   shin_d = {shin_q[3:0], line_lvl};
               default:             shin_d = shin_q;
            endcase
            if (incnt_q + nbits >= sfp_pkg::CNT_BYTE) begin
               incnt_d = sfp_pkg::CNT_ZERO;
               rxv_d   = 1'b1;
               rxb_d   = shin_d;
            end else begin
               incnt_d = incnt_q + nbits;
            end
         end
         if (!ctl.rd_phase) begin
            outcnt_d = sfp_pkg::CNT_ZERO;
            oe_d     = sfp_pkg::LINES_OFF;
         end else if (sclk_fall) begin
            // Drive out on falling edges, fetching a byte at each boundary
            tx_d = (outcnt_q == sfp_pkg::CNT_ZERO) ? tx_data : tx_q;
            take_d = (outcnt_q == sfp_pkg::CNT_ZERO);
            unique case (lanes)
               sfp_pkg::SFP_SINGLE: begin
                  do_d = {2'b00, tx_d[7], 1'b0};
                  oe_d = 4'h2;
                  tx_d = {tx_d[6:0], 1'b0};
               end
               sfp_pkg::SFP_DUAL: begin
                  do_d = {2'b00, tx_d[7:6]};
                  oe_d = 4'h3;
                  tx_d = {tx_d[5:0], 2'b00};
               end
               sfp_pkg::SFP_QUAD: begin
                  do_d = tx_d[7:4];
                  oe_d = 4'hF;
                  tx_d = {tx_d[3:0], 4'h0};
               end
               default: begin
                  do_d = do_q;
               end
            endcase
            outcnt_d = (outcnt_q + nbits >= sfp_pkg::CNT_BYTE) ?
                       sfp_pkg::CNT_ZERO : outcnt_q + nbits;
         end
      end
      // A paused transfer keeps every counter and shifter as it was
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed_q  <= 1'b0;
         pause_q  <= 1'b0;
         shin_q   <= sfp_pkg::BYTE_ZERO;
         incnt_q  <= sfp_pkg::CNT_ZERO;
         rxb_q    <= sfp_pkg::BYTE_ZERO;
         rxv_q    <= 1'b0;
         tx_q     <= sfp_pkg::BYTE_ZERO;
         outcnt_q <= sfp_pkg::CNT_ZERO;
         do_q     <= sfp_pkg::LINES_OFF;
         oe_q     <= sfp_pkg::LINES_OFF;
         take_q   <= 1'b0;
      end else begin
         armed_q  <= armed_d;
         pause_q  <= pause_d;
         shin_q   <= shin_d;
         incnt_q  <= incnt_d;
         rxb_q    <= rxb_d;
         rxv_q    <= rxv_d;
         tx_q     <= tx_d;
         outcnt_q <= outcnt_d;
         do_q     <= do_d;
         oe_q     <= oe_d;
         take_q   <= take_d;
      end
   end

   // ==========================================================
   // Outputs
   // Enables are gated at once so a pause or deselect floats the lines
   assign drive.line_o  = do_q;
   assign drive.line_oe = (active && ctl.rd_phase) ? oe_q : sfp_pkg::LINES_OFF;
   assign tx_take       = take_q;
   assign rx.valid      = rxv_q;
   assign rx.data       = rxb_q;
   assign selected      = sel;
   assign frame_start   = cs_fall && armed_q;
   assign paused        = pause_q;
   assign quad_refused  = sel && ctl.lanes == sfp_pkg::SFP_QUAD && !quad_ok;
   // Line 2 is data under quad enable, so its protect meaning is dropped
   assign wr_status_block = sr_protect && !wp_lvl && !quad_enable_bit;

   // ==========================================================
   // Checks
   property p_desel_float;
      @(posedge clk) disable iff (!rst_n) cs_n_lvl |-> drive.line_oe == sfp_pkg::LINES_OFF;
   endproperty
   a_desel_float: assert property (p_desel_float) else $error("line driven while deselected");

   property p_unarmed_quiet;
      @(posedge clk) disable iff (!rst_n) !armed_q |=> !rx.valid;
   endproperty
   a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("byte taken before arming");

   property p_rx_on_rise;
      @(posedge clk) disable iff (!rst_n) rx.valid |-> $past(sclk_rise) && $past(active);
   endproperty
   a_rx_on_rise: assert property (p_rx_on_rise) else $error("byte not closed by rising edge");

   property p_out_on_fall;
      @(posedge clk) disable iff (!rst_n) $changed(do_q) |-> $past(sclk_fall);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a falling edge");

   property p_quad_gate;
      @(posedge clk) disable iff (!rst_n) drive.line_oe[3] |-> quad_enable_bit;
   endproperty
   a_quad_gate: assert property (p_quad_gate) else $error("line 3 driven without quad enable");

   property p_wp_block;
      @(posedge clk) disable iff (!rst_n)
         (sr_protect && !wp_lvl) |-> (wr_status_block == !quad_enable_bit);
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("write protect decision wrong");

   property p_pause_float;
      @(posedge clk) disable iff (!rst_n) pause_q |-> drive.line_oe == sfp_pkg::LINES_OFF;
   endproperty
   a_pause_float: assert property (p_pause_float) else $error("line driven during pause");

   // Two paused cycles in a row must leave the shifters untouched
   property p_pause_keeps;
      @(posedge clk) disable iff (!rst_n)
         (pause_q && $past(pause_q)) |-> $stable(shin_q) && $stable(incnt_q) && $stable(tx_q);
   endproperty
   a_pause_keeps: assert property (p_pause_keeps) else $error("state moved during pause");

   property p_qe_no_pause;
      @(posedge clk) disable iff (!rst_n) quad_enable_bit |=> !pause_q;
   endproperty
   a_qe_no_pause: assert property (p_qe_no_pause) else $error("pause under quad enable");

   property p_pause_start;
      @(posedge clk) disable iff (!rst_n)
         (sel && !quad_enable_bit && !sclk_lvl && !hold_lvl) |=> pause_q;
   endproperty
   a_pause_start: assert property (p_pause_start) else $error("pause did not start");

   property p_drive_read_only;
      @(posedge clk) disable iff (!rst_n) (drive.line_oe != sfp_pkg::LINES_OFF) |-> ctl.rd_phase;
   endproperty
   a_drive_read_only: assert property (p_drive_read_only) else $error("drive outside read");

endmodule

// *** verif/sfp_host_model.sv ***
// Purpose: Host controller model driving the flash pins
// Assumes: Half serial clock period is H system cycles
// Notes:   Undriven lines 0/1 toggle, lines 2/3 have pull-ups
`timescale 1ns/1ns
module sfp_host_model #(
   parameter int H = 8
) (
   input  wire logic                clk,
   output sfp_pkg::sfp_pins_t       pins,
   input  wire sfp_pkg::sfp_drive_t drive
);
   logic       cs_q   = 1'b1;
   logic       sclk_q = 1'b0;
   logic       idle_q = 1'b0;
   logic       flip_q = 1'b0;
   logic [3:0] o      = 4'hC;
   logic [3:0] oe     = 4'hD;
   logic [3:0] res;

   // ==========
   // Wire levels
   // A released line must not look like held data
   always @(posedge clk) flip_q <= ~flip_q;
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         res[k] = drive.line_oe[k] ? drive.line_o[k] : oe[k] ? o[k] : (k >= 2) | flip_q;
      end
   end
   assign pins = {cs_q, sclk_q, res};

   // ==========
   // Host cycles
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Clock parked at the idle level before select falls
   task automatic sel(input logic idle);
      idle_q = idle;
      sclk_q = idle;
      tick(H);
      cs_q = 1'b0;
      tick(H);
   endtask

   task automatic desel;
      sclk_q = idle_q;
      tick(H);
      cs_q = 1'b1;
      o = 4'hC;
      tick(H);
   endtask

   // Data set while clock is low, taken on the rise
   task automatic wr(input logic [7:0] b, input int w, input int n);
      logic [7:0] s;
      s = b;
      oe = (w == 1) ? 4'hD : 4'hF;
      for (int i = 0; i < n; i++) begin
         sclk_q = 1'b0;
         if (w == 4) o = s[7:4];
         else if (w == 2) o[1:0] = s[7:6];
         else o[0] = s[7];
         s = s << w;
         tick(H);
         sclk_q = 1'b1;
         tick(H);
      end
   endtask

   // Sampled late in the low half, after the device moved on the fall
   task automatic rd(input int w, output logic [7:0] b);
      b = 8'h00;
      oe = (w == 1) ? 4'hD : (w == 2) ? 4'hC : 4'h0;
      for (int i = 0; i < 8 / w; i++) begin
         sclk_q = 1'b1;
         tick(H);
         sclk_q = 1'b0;
         tick(H);
         if (w == 1) b = {b[6:0], res[1]};
         else if (w == 2) b = {b[5:0], res[1:0]};
         else b = {b[3:0], res};
      end
   endtask
endmodule

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the flash pin interface
// Assumes: Host model half period of H system cycles
// Notes:   Each scenario judges its own results
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", nm, (e), (g)); end end
module tb;
   localparam int H = 8;
   logic                clk;
   logic                rst_n;
   logic                qe;
   logic                srp;
   logic [7:0]          tx_data;
   sfp_pkg::sfp_ctl_t   ctl;
   sfp_pkg::sfp_pins_t  pins;
   sfp_pkg::sfp_drive_t drive;
   sfp_pkg::sfp_rx_t    rx;
   logic                tx_take, selected, frame_start, paused, quad_refused, wr_block;
   logic [7:0]          rx_last = 8'h00;
   int                  rx_cnt = 0, take_cnt = 0, n_fail = 0, check_count = 0, cyc = 0;
   int                  fs_cnt = 0;

   sfp_pin_if sfp_pin_if_inst (.clk(clk), .rst_n(rst_n), .pins(pins), .drive(drive),
      .quad_enable_bit(qe), .sr_protect(srp), .ctl(ctl), .tx_data(tx_data),
      .tx_take(tx_take), .rx(rx), .selected(selected), .frame_start(frame_start),
      .paused(paused), .quad_refused(quad_refused), .wr_status_block(wr_block));
   sfp_host_model #(.H(H)) hm (.clk(clk), .pins(pins), .drive(drive));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========
   // Monitors and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rx.valid === 1'b1) rx_last <= rx.data;
      if (rx.valid === 1'b1) rx_cnt <= rx_cnt + 1;
      if (tx_take === 1'b1) take_cnt <= take_cnt + 1;
      if (frame_start === 1'b1) fs_cnt <= fs_cnt + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   task automatic results;
      if (n_fail == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic rxchk(input logic [7:0] e, input int c);
      hm.tick(10);
      `CHK("rx byte", e, rx_last)
      `CHK("rx count", c + 1, rx_cnt)
   endtask

   // ==========
   // Scenarios
   task automatic s_idle;
      `CHK("selected", 1'b0, selected)
      `CHK("oe idle", 4'h0, drive.line_oe)
   endtask

   task automatic s_write;
      int c;
      for (int m = 0; m < 2; m++) begin
         c = rx_cnt;
         hm.sel(m[0]);
         `CHK("selected", 1'b1, selected)
         hm.wr(m ? 8'h5B : 8'hA5, 1, 8);
         rxchk(m ? 8'h5B : 8'hA5, c);
         hm.desel();
      end
   endtask

   task automatic s_lanes;
      logic [7:0] b;
      logic [3:0] e;
      int         w, c;
      qe = 1'b1;
      for (int l = 0; l < 3; l++) begin
         w = 1 << l;
         e = (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hF;
         ctl.lanes = sfp_pkg::sfp_lanes_t'(l);
         hm.sel(1'b0);
         c = rx_cnt;
         hm.wr(8'h5A + 8'(l), w, 8 / w);
         rxchk(8'h5A + 8'(l), c);
         `CHK("oe write", 4'h0, drive.line_oe)
         tx_data = 8'hC3 ^ 8'(l);
         ctl.rd_phase = 1'b1;
         c = take_cnt;
         hm.rd(w, b);
         `CHK("read byte", 8'hC3 ^ 8'(l), b)
         `CHK("oe read", e, drive.line_oe)
         `CHK("takes", c + 1, take_cnt)
         hm.desel();
         `CHK("oe desel", 4'h0, drive.line_oe)
         ctl.rd_phase = 1'b0;
      end
      ctl.lanes = sfp_pkg::SFP_SINGLE;
      qe = 1'b0;
   endtask

   task automatic s_refuse;
      int c;
      ctl.lanes = sfp_pkg::SFP_QUAD;
      c = rx_cnt;
      hm.sel(1'b0);
      `CHK("refused", 1'b1, quad_refused)
      hm.wr(8'h96, 1, 8);
      rxchk(8'h96, c);
      hm.desel();
      ctl.lanes = sfp_pkg::SFP_SINGLE;
      `CHK("refused", 1'b0, quad_refused)
   endtask

   task automatic s_protect;
      for (int i = 0; i < 8; i++) begin
         srp = i[0];
         hm.o[2] = i[1];
         qe = i[2];
         hm.tick(6);
         `CHK("wr block", i[0] & ~i[1] & ~i[2], wr_block)
      end
      hm.o[2] = 1'b1;
      qe = 1'b0;
   endtask

   // Select stays low through the pause, else framing restarts
   task automatic s_pause;
      int c;
      c = rx_cnt;
      hm.sel(1'b0);
      hm.wr(8'hB4, 1, 4);
      hm.o[3] = 1'b0;
      hm.tick(H);
      `CHK("paused", 1'b0, paused)
      hm.sclk_q = 1'b0;
      hm.tick(H);
      `CHK("paused", 1'b1, paused)
      `CHK("oe pause", 4'h0, drive.line_oe)
      hm.o[0] = ~hm.o[0];
      hm.sclk_q = 1'b1;
      hm.tick(H);
      hm.sclk_q = 1'b0;
      hm.tick(H);
      hm.o[3] = 1'b1;
      hm.tick(H);
      `CHK("paused", 1'b0, paused)
      hm.wr(8'h40, 1, 4);
      rxchk(8'hB4, c);
      hm.desel();
      qe = 1'b1;
      hm.sel(1'b0);
      hm.o[3] = 1'b0;
      hm.tick(H);
      `CHK("paused", 1'b0, paused)
      hm.desel();
      qe = 1'b0;
   endtask

   task automatic s_partial;
      int c;
      int f;
      c = rx_cnt;
      f = fs_cnt;
      hm.sel(1'b0);
      hm.wr(8'hF0, 1, 4);
      hm.desel();
      `CHK("selected", 1'b0, selected)
      hm.sel(1'b0);
      hm.wr(8'h69, 1, 8);
      rxchk(8'h69, c);
      `CHK("frames", f + 2, fs_cnt)
      hm.desel();
   endtask

   initial begin
      rst_n   = 1'b0;
      qe      = 1'b0;
      srp     = 1'b0;
      tx_data = 8'h00;
      ctl     = '0;
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      hm.tick(4);
      s_idle();
      s_write();
      s_lanes();
      s_refuse();
      s_protect();
      s_pause();
      s_partial();
      results();
   end
endmodule
